//--- ecs_top.sv
// External bus control: code select strap, fetch strobe, stall, bus registers
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns

// Summary of operation
// - An external code fetch drives the program store strobe low to enable memory.
// - The program store strobe stays high outside external code fetch cycles.
// - The code select pin level is caught at reset release and kept for all later fetches.
// - A caught value of 0 sends every code fetch to external memory.
// - A caught value of 1 sends fetches below the internal limit inside, the rest outside.
// - After reset release the same pin serves as the bus stall input.
// - A high stall input in the last timed cycle of an external access extends it until the input falls.
// - Bus timing high byte sits at index 469 and resets to ff.
// - Bus timing low byte sits at index 468, resets to ef, and its bit 4 is unimplemented.
// - Bus config resets to 0000 0a11 with bit 2 taken from the bus width strap.
module ecs_top
  import ecs_pkg::*;
#(
  parameter logic [19:0] INT_CODE_LIMIT = DEF_INT_CODE_LIMIT
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // AXI4-Lite write address
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [15:0] i_awaddr,
  // AXI4-Lite write data
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  // AXI4-Lite write response
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  // AXI4-Lite read address
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [15:0] i_araddr,
  // AXI4-Lite read data
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // Core access request and answer
  input  wire logic        i_core_valid,
  input  wire ecs_req_s    i_core_req,
  output logic             o_core_ready,
  output logic             o_core_done,
  output logic             o_core_err,
  output logic             o_core_int_code,
  output logic [15:0]      o_core_rdata,
  // Straps and stall pin
  input  wire logic        i_code_select_stall_pin,
  input  wire logic        i_bus_width_strap,
  // External bus
  output logic [19:0]      o_ext_addr,
  output logic [15:0]      o_ext_wdata,
  input  wire logic [15:0] i_ext_rdata,
  output logic             o_program_store_strobe_n,
  output logic             o_data_read_strobe_n,
  output logic             o_data_write_strobe_n
);

  // Register file
  logic [7:0]  bus_timing_low_ff;
  logic [7:0]  bus_timing_high_ff;
  logic [7:0]  bus_config_ff;

  // Strap capture
  logic        strap_taken_ff;
  logic        external_code_select_ff;

  // AXI write side
  logic        aw_held_ff;
  logic [15:0] aw_addr_ff;
  logic        w_held_ff;
  logic [7:0]  w_byte_ff;
  logic        w_lane_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;

  // AXI read side
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  // Bus cycle machine
  ecs_state_e  state_ff;
  ecs_state_e  nxt_state;
  logic [1:0]  cnt_ff;
  logic [1:0]  nxt_cnt;
  ecs_kind_e   kind_ff;
  logic        done_ff;
  logic        err_ff;
  logic        int_code_ff;
  logic [15:0] core_rdata_ff;
  logic [19:0] ext_addr_ff;
  logic [15:0] ext_wdata_ff;
  logic        pse_n_ff;
  logic        rd_n_ff;
  logic        wr_n_ff;

  // Stall input after synchronisation
  logic        stall_sync;

  ecs_sync #(
    .W (1)
  ) u_stall_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      (i_code_select_stall_pin),
    .o_q      (stall_sync)
  );

  // ---------------- Strap capture at reset release
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_taken_ff          <= 1'b0;
      external_code_select_ff <= 1'b0;
    end else if (!strap_taken_ff) begin
      strap_taken_ff          <= 1'b1;
      external_code_select_ff <= i_code_select_stall_pin;
    end
  end

  // ---------------- AXI write path
  wire aw_take  = i_awvalid & o_awready;
  wire w_take   = i_wvalid & o_wready;
  wire wr_fire  = aw_held_ff & w_held_ff & ~bvalid_ff;

  assign o_awready = ~aw_held_ff & ~bvalid_ff;
  assign o_wready  = ~w_held_ff & ~bvalid_ff;

  wire hit_w_low  = ecs_hit(aw_addr_ff, IDX_BUS_TIMING_LOW);
  wire hit_w_high = ecs_hit(aw_addr_ff, IDX_BUS_TIMING_HIGH);
  wire hit_w_cfg  = ecs_hit(aw_addr_ff, IDX_BUS_CONFIG);
  wire hit_w_stat = ecs_hit(aw_addr_ff, IDX_BUS_STATUS);
  wire hit_w_any  = hit_w_low | hit_w_high | hit_w_cfg | hit_w_stat;

  wire wr_en      = wr_fire & w_lane_ff;
  wire wr_low     = wr_en & hit_w_low;
  wire wr_high    = wr_en & hit_w_high;
  wire wr_cfg     = wr_en & hit_w_cfg;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 16'h0000;
    end else if (aw_take) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= i_awaddr;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      w_held_ff <= 1'b0;
      w_byte_ff <= 8'h00;
      w_lane_ff <= 1'b0;
    end else if (w_take) begin
      w_held_ff <= 1'b1;
      w_byte_ff <= i_wdata[7:0];
      w_lane_ff <= i_wstrb[0];
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= hit_w_any ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_ff;
  assign o_bresp  = bresp_ff;

  // ---------------- Registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_timing_high_ff <= RST_BUS_TIMING_HIGH;
    end else if (wr_high) begin
      bus_timing_high_ff <= w_byte_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_timing_low_ff <= RST_BUS_TIMING_LOW;
    end else if (wr_low) begin
      bus_timing_low_ff <= w_byte_ff & MASK_BUS_TIMING_LOW;
    end
  end

  // Width strap joins the config once, in the cycle the straps are caught
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_config_ff <= RST_BUS_CONFIG;
    end else if (!strap_taken_ff) begin
      bus_config_ff[CFG_ADDR_SIZE_BIT2] <= i_bus_width_strap;
    end else if (wr_cfg) begin
      bus_config_ff <= w_byte_ff & MASK_BUS_CONFIG;
    end
  end

  // ---------------- AXI read path
  wire ar_take    = i_arvalid & o_arready;
  wire hit_r_low  = ecs_hit(i_araddr, IDX_BUS_TIMING_LOW);
  wire hit_r_high = ecs_hit(i_araddr, IDX_BUS_TIMING_HIGH);
  wire hit_r_cfg  = ecs_hit(i_araddr, IDX_BUS_CONFIG);
  wire hit_r_stat = ecs_hit(i_araddr, IDX_BUS_STATUS);
  wire hit_r_any  = hit_r_low | hit_r_high | hit_r_cfg | hit_r_stat;

  wire busy = (state_ff != ECS_ST_IDLE);

  wire [7:0] status_byte = {4'h0, busy, strap_taken_ff, stall_sync,
                            external_code_select_ff};

  wire [7:0] rd_byte;
  assign rd_byte = hit_r_low  ? bus_timing_low_ff  :
                   hit_r_high ? bus_timing_high_ff :
                   hit_r_cfg  ? bus_config_ff      :
                   hit_r_stat ? status_byte        : 8'h00;

  assign o_arready = ~rvalid_ff;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h00_0000, rd_byte};
      rresp_ff  <= hit_r_any ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign o_rvalid = rvalid_ff;
  assign o_rdata  = rdata_ff;
  assign o_rresp  = rresp_ff;

  // ---------------- Core request routing
  // Requests wait until the strap is caught; the pin is a stall input after that
  assign o_core_ready = (state_ff == ECS_ST_IDLE) & strap_taken_ff;

  wire accept    = i_core_valid & o_core_ready;
  wire is_code   = (i_core_req.kind == ECS_KIND_CODE);
  wire below_lim = (i_core_req.addr < INT_CODE_LIMIT);
  wire go_int    = is_code & external_code_select_ff & below_lim;
  wire ext_off   = bus_config_ff[CFG_EXT_BUS_DISABLE];

  // Stall only counts once the pin has changed role
  wire stall_on  = stall_sync & strap_taken_ff &
                   ~bus_config_ff[CFG_STALL_DISABLE];

  wire [1:0] code_len  = bus_timing_low_ff[TL_CODE_LSB +: 2];
  wire [1:0] read_len  = bus_timing_high_ff[TH_READ_LSB +: 2];
  wire [1:0] write_len = bus_timing_high_ff[TH_WRITE_LSB +: 2];
  wire [1:0] len_sel   = is_code ? code_len :
                         (i_core_req.kind == ECS_KIND_WRITE) ? write_len : read_len;

  wire start_ext = accept & ~go_int & ~ext_off;
  wire finish    = ((state_ff == ECS_ST_EXT) & (cnt_ff == 2'd0) & ~stall_on) |
                   ((state_ff == ECS_ST_STALL) & ~stall_on);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ECS_ST_IDLE: begin
        if (start_ext) begin
          nxt_state = ECS_ST_EXT;
          nxt_cnt   = len_sel;
        end
      end
      ECS_ST_EXT: begin
        if (cnt_ff != 2'd0) begin
          nxt_cnt = cnt_ff - 2'd1;
        end else if (stall_on) begin
          nxt_state = ECS_ST_STALL;
        end else begin
          nxt_state = ECS_ST_IDLE;
        end
      end
      ECS_ST_STALL: begin
        if (!stall_on) begin
          nxt_state = ECS_ST_IDLE;
        end
      end
      default: begin
        nxt_state = ECS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= ECS_ST_IDLE;
      cnt_ff   <= 2'd0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ---------------- Answer to the core
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_ff     <= 1'b0;
      err_ff      <= 1'b0;
      int_code_ff <= 1'b0;
    end else begin
      done_ff     <= (accept & (go_int | ext_off)) | finish;
      err_ff      <= accept & ~go_int & ext_off;
      int_code_ff <= accept & go_int;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      core_rdata_ff <= 16'h0000;
    end else if (finish && kind_ff != ECS_KIND_WRITE) begin
      core_rdata_ff <= i_ext_rdata;
    end
  end

  assign o_core_done     = done_ff;
  assign o_core_err      = err_ff;
  assign o_core_int_code = int_code_ff;
  assign o_core_rdata    = core_rdata_ff;

  // ---------------- External bus outputs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      kind_ff      <= ECS_KIND_CODE;
      ext_addr_ff  <= 20'h00000;
      ext_wdata_ff <= 16'h0000;
    end else if (start_ext) begin
      kind_ff      <= i_core_req.kind;
      ext_addr_ff  <= i_core_req.addr;
      ext_wdata_ff <= i_core_req.wdata;
    end
  end

  // Strobes fall with the cycle start and rise with its finish
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pse_n_ff <= 1'b1;
      rd_n_ff  <= 1'b1;
      wr_n_ff  <= 1'b1;
    end else if (start_ext) begin
      pse_n_ff <= ~is_code;
      rd_n_ff  <= ~(i_core_req.kind == ECS_KIND_READ);
      wr_n_ff  <= ~(i_core_req.kind == ECS_KIND_WRITE);
    end else if (finish) begin
      pse_n_ff <= 1'b1;
      rd_n_ff  <= 1'b1;
      wr_n_ff  <= 1'b1;
    end
  end

  assign o_ext_addr               = ext_addr_ff;
  assign o_ext_wdata              = ext_wdata_ff;
  assign o_program_store_strobe_n = pse_n_ff;
  assign o_data_read_strobe_n     = rd_n_ff;
  assign o_data_write_strobe_n    = wr_n_ff;

endmodule : ecs_top

//--- ecs_pkg.sv
// Shared constants and types for the external bus code select block
package ecs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_BUS_TIMING_LOW  = 16'h0468;
  localparam logic [15:0] IDX_BUS_TIMING_HIGH = 16'h0469;
  localparam logic [15:0] IDX_BUS_CONFIG      = 16'h046a;
  localparam logic [15:0] IDX_BUS_STATUS      = 16'h046b;

  // Values after reset and implemented-bit masks
  localparam logic [7:0] RST_BUS_TIMING_LOW  = 8'hef;
  localparam logic [7:0] RST_BUS_TIMING_HIGH = 8'hff;
  localparam logic [7:0] RST_BUS_CONFIG      = 8'h03;
  localparam logic [7:0] MASK_BUS_TIMING_LOW = 8'hef;
  localparam logic [7:0] MASK_BUS_CONFIG     = 8'h1f;

  // Bus config fields
  localparam int CFG_STALL_DISABLE    = 4;
  localparam int CFG_EXT_BUS_DISABLE  = 3;
  localparam int CFG_ADDR_SIZE_BIT2   = 2;

  // Timing field low bit positions (two-bit fields)
  localparam int TL_CODE_LSB  = 2;
  localparam int TH_READ_LSB  = 2;
  localparam int TH_WRITE_LSB = 6;

  // Status fields
  localparam int STAT_CODE_SEL    = 0;
  localparam int STAT_STALL       = 1;
  localparam int STAT_STRAP_TAKEN = 2;
  localparam int STAT_BUSY        = 3;

  // Internal program memory limit, first external code address
  localparam logic [19:0] DEF_INT_CODE_LIMIT = 20'h08000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ECS_KIND_CODE  = 2'b00,
    ECS_KIND_READ  = 2'b01,
    ECS_KIND_WRITE = 2'b10
  } ecs_kind_e;

  typedef enum logic [1:0] {
    ECS_ST_IDLE  = 2'b00,
    ECS_ST_EXT   = 2'b01,
    ECS_ST_STALL = 2'b10
  } ecs_state_e;

  typedef struct packed {
    logic [19:0] addr;
    ecs_kind_e   kind;
    logic [15:0] wdata;
  } ecs_req_s;

  // Byte address of a register index matches the bus address
  function automatic logic ecs_hit(input logic [15:0] addr, input logic [15:0] idx);
    return addr == {idx[13:0], 2'b00};
  endfunction : ecs_hit

endpackage : ecs_pkg

//--- ecs_sync.sv
// Two-stage level synchroniser
`timescale 1ns/1ns
module ecs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  // Level in and out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end

  assign o_q = sync_ff;

endmodule : ecs_sync

//--- ecs_assertions.sv
// Port-level assertions for the external bus code select block
`timescale 1ns/1ns
module ecs_assertions
  import ecs_pkg::*;
#(
  parameter logic [19:0] INT_CODE_LIMIT = DEF_INT_CODE_LIMIT
) (
  // Clock, reset and register read
  input wire logic     i_clk,
  input wire logic     i_arst_n,
  input wire logic     i_arvalid,
  input wire logic     o_arready,
  input wire logic     o_rvalid,
  // Core side and pins
  input wire logic     i_core_valid,
  input wire ecs_req_s i_core_req,
  input wire logic     o_core_ready,
  input wire logic     o_core_done,
  input wire logic     o_core_err,
  input wire logic     o_core_int_code,
  input wire logic     i_code_select_stall_pin,
  input wire logic     o_program_store_strobe_n,
  input wire logic     o_data_read_strobe_n,
  input wire logic     o_data_write_strobe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire pse = !o_program_store_strobe_n;
  sequence ext_code_take;
    i_core_valid && o_core_ready && i_core_req.kind == ECS_KIND_CODE
      && i_core_req.addr >= INT_CODE_LIMIT;
  endsequence
  sequence stall_held;
    i_code_select_stall_pin [*3] ##0 pse;
  endsequence
  ext_fetch_strobe_a: assert property (ext_code_take |=> pse || o_core_err)
    else $error("external fetch without strobe");
  strobe_code_only_a: assert property (pse |-> o_data_read_strobe_n && o_data_write_strobe_n)
    else $error("strobe during data access");
  int_no_strobe_a: assert property (o_core_int_code |-> $past(!pse) && o_core_done)
    else $error("internal fetch used strobe");
  ready_after_rst_a: assert property (!$past(i_arst_n) |-> !o_core_ready)
    else $error("ready before strap caught");
  stall_extends_a: assert property (stall_held |=> pse)
    else $error("stall did not extend cycle");
  stall_release_a: assert property ($fell(i_code_select_stall_pin) && pse |-> ##[1:8] !pse)
    else $error("cycle not ended after stall");
  done_on_rise_a: assert property ($rose(o_program_store_strobe_n) |-> o_core_done)
    else $error("strobe end without done");
  read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("register read not answered");
  err_no_strobe_a: assert property (o_core_err |-> o_core_done && !pse)
    else $error("bus error with strobe");
endmodule : ecs_assertions

bind ecs_top ecs_assertions #(.INT_CODE_LIMIT(INT_CODE_LIMIT)) u_chk (
  .i_clk, .i_arst_n, .i_arvalid, .o_arready, .o_rvalid, .i_core_valid, .i_core_req,
  .o_core_ready, .o_core_done, .o_core_err, .o_core_int_code, .i_code_select_stall_pin,
  .o_program_store_strobe_n, .o_data_read_strobe_n, .o_data_write_strobe_n
);

//--- ecs_mem_model.sv
// Behavioural external program and data memory
`timescale 1ns/1ns
module ecs_mem_model (
  // Clock
  input  wire logic        i_clk,
  // Bus from the block
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_pse_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  output logic      [15:0] o_rdata
);
  logic [15:0] mem_ff [16];
  logic [15:0] last_ff = 16'h0;
  wire  [15:0] code_word = {i_addr[7:0], ~i_addr[7:0]};
  // Released bus toggles so stale data never looks valid
  assign o_rdata = !i_pse_n ? code_word : !i_rd_n ? mem_ff[i_addr[3:0]] : ~last_ff;
  always @(posedge i_clk) begin
    last_ff <= o_rdata;
    if (!i_wr_n) mem_ff[i_addr[3:0]] <= i_wdata;
  end
endmodule : ecs_mem_model

//--- ecs_top_tb_top.sv
// Self-checking bench for the external bus code select block
`timescale 1ns/1ns
module ecs_top_tb_top
  import ecs_pkg::*;
;
  logic        i_clk = '0, i_arst_n = '0, i_awvalid = '0, i_wvalid = '0, i_bready = '0;
  logic        i_arvalid = '0, i_rready = '0, i_core_valid = '0;
  logic        i_code_select_stall_pin = '0, i_bus_width_strap = '0;
  logic [15:0] i_awaddr = '0, i_araddr = '0;
  logic [31:0] i_wdata = '0;
  logic [3:0]  i_wstrb = 4'h1;
  ecs_req_s    i_core_req = '0;
  wire  [15:0] i_ext_rdata;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_core_ready;
  logic        o_core_done, o_core_err, o_core_int_code, o_program_store_strobe_n;
  logic        o_data_read_strobe_n, o_data_write_strobe_n;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [15:0] o_core_rdata, o_ext_wdata;
  logic [19:0] o_ext_addr;
  logic        ic;
  int          n_mismatch = 0, compares = 0, cyc = 0, np, nd;

  ecs_top dut (
    .i_clk, .i_arst_n, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
    .i_rready, .o_rdata, .o_rresp, .i_core_valid, .i_core_req, .o_core_ready, .o_core_done,
    .o_core_err, .o_core_int_code, .o_core_rdata, .i_code_select_stall_pin, .i_bus_width_strap,
    .o_ext_addr, .o_ext_wdata, .i_ext_rdata, .o_program_store_strobe_n, .o_data_read_strobe_n,
    .o_data_write_strobe_n
  );
  ecs_mem_model u_mem (
    .i_clk, .i_addr(o_ext_addr), .i_wdata(o_ext_wdata), .i_pse_n(o_program_store_strobe_n),
    .i_rd_n(o_data_read_strobe_n), .i_wr_n(o_data_write_strobe_n), .o_rdata(i_ext_rdata)
  );

  initial forever #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task summarize;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk

  task rst(input logic s, input logic b);
    @(posedge i_clk);
    i_arst_n <= 1'h0;
    i_code_select_stall_pin <= s;
    i_bus_width_strap <= b;
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_code_select_stall_pin <= 1'h0;
  endtask : rst

  task wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] e);
    logic ah, wh, bh;
    logic [1:0] r;
    @(posedge i_clk);
    i_awvalid <= 1'h1;
    i_awaddr <= a;
    i_wvalid <= 1'h1;
    i_wdata <= {24'h0, d};
    i_bready <= 1'h1;
    do begin
      @(negedge i_clk);
      ah = i_awvalid & o_awready;
      wh = i_wvalid & o_wready;
      bh = o_bvalid === 1'h1;
      r = o_bresp;
      @(posedge i_clk);
      if (ah) i_awvalid <= 1'h0;
      if (wh) i_wvalid <= 1'h0;
    end while (!bh);
    i_bready <= 1'h0;
    chk(r, e, "write response");
  endtask : wr

  task rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] e);
    logic ah, h;
    logic [31:0] v;
    logic [1:0] r;
    @(posedge i_clk);
    i_arvalid <= 1'h1;
    i_araddr <= a;
    i_rready <= 1'h1;
    do begin
      @(negedge i_clk);
      ah = i_arvalid & o_arready;
      h = o_rvalid === 1'h1;
      v = o_rdata;
      r = o_rresp;
      @(posedge i_clk);
      if (ah) i_arvalid <= 1'h0;
    end while (!h);
    i_rready <= 1'h0;
    chk(v, {24'h0, d}, "read data");
    chk(r, e, "read response");
  endtask : rd

  task core(input ecs_kind_e k, input logic [19:0] a, input logic [15:0] w);
    int n;
    n = 0;
    np = 0;
    nd = 0;
    ic = 1'h0;
    @(posedge i_clk);
    i_core_valid <= 1'h1;
    i_core_req <= '{addr: a, kind: k, wdata: w};
    do begin
      @(negedge i_clk);
      n++;
    end while (o_core_ready !== 1'h1 && n < 200);
    @(posedge i_clk);
    i_core_valid <= 1'h0;
    do begin
      @(negedge i_clk);
      n++;
      np += (o_program_store_strobe_n === 1'h0);
      nd += (o_data_read_strobe_n === 1'h0 || o_data_write_strobe_n === 1'h0);
      if (o_core_int_code === 1'h1) ic = 1'h1;
    end while (o_core_done !== 1'h1 && n < 400);
    chk(o_core_done, 1'h1, "core done");
  endtask : core

  task t_regs;
    rd(16'h11a0, 8'hef, RESP_OKAY);
    rd(16'h11a4, 8'hff, RESP_OKAY);
    rd(16'h11a8, 8'h07, RESP_OKAY);
    rd(16'h11ac, 8'h05, RESP_OKAY);
    wr(16'h11a0, 8'hff, RESP_OKAY);
    rd(16'h11a0, 8'hef, RESP_OKAY);
    wr(16'h11a4, 8'h00, RESP_OKAY);
    rd(16'h11a4, 8'h00, RESP_OKAY);
    wr(16'h1200, 8'h5a, RESP_SLVERR);
    rd(16'h1200, 8'h00, RESP_SLVERR);
  endtask : t_regs

  task t_sel1;
    core(ECS_KIND_CODE, 20'h07fff, 16'h0);
    chk(np, 0, "internal fetch strobe");
    chk({31'h0, ic}, 32'h1, "internal fetch");
    core(ECS_KIND_CODE, 20'h08000, 16'h0);
    chk(np, 4, "external fetch length");
    chk({31'h0, ic}, 32'h0, "external fetch not internal");
    chk(o_core_rdata, 16'h00ff, "external fetch data");
    wr(16'h11a0, 8'he3, RESP_OKAY);
    core(ECS_KIND_CODE, 20'h08012, 16'h0);
    chk(np, 1, "short fetch length");
    chk(o_core_rdata, 16'h12ed, "short fetch data");
    chk({12'h000, o_ext_addr}, 32'h0000_8012, "fetch address");
  endtask : t_sel1

  task t_data;
    core(ECS_KIND_WRITE, 20'h10003, 16'hbeef);
    chk(np, 0, "data write no fetch strobe");
    chk(nd, 1, "data write strobes");
    core(ECS_KIND_READ, 20'h10003, 16'h0);
    chk(np, 0, "data read no fetch strobe");
    chk(nd, 1, "data read strobes");
    chk(o_core_rdata, 16'hbeef, "data read value");
  endtask : t_data

  task t_stall;
    @(posedge i_clk);
    i_code_select_stall_pin <= 1'h1;
    fork
      core(ECS_KIND_CODE, 20'h0a000, 16'h0);
      begin
        repeat (6) @(posedge i_clk);
        i_code_select_stall_pin <= 1'h0;
      end
    join
    chk(np > 4 && np < 10, 1, "stalled fetch length");
    wr(16'h11a8, 8'hf7, RESP_OKAY);
    rd(16'h11a8, 8'h17, RESP_OKAY);
    // Stall disabled: a two-cycle stall must not stretch the fetch
    @(posedge i_clk);
    i_code_select_stall_pin <= 1'h1;
    fork
      core(ECS_KIND_CODE, 20'h0a000, 16'h0);
      begin
        repeat (2) @(posedge i_clk);
        i_code_select_stall_pin <= 1'h0;
      end
    join
    chk(np, 1, "stall disabled length");
    wr(16'h11a8, 8'h0f, RESP_OKAY);
    core(ECS_KIND_CODE, 20'h0a000, 16'h0);
    chk({31'h0, o_core_err}, 32'h1, "bus disabled error");
    chk(np, 0, "bus disabled no strobe");
  endtask : t_stall

  task t_sel0;
    rd(16'h11a8, 8'h03, RESP_OKAY);
    rd(16'h11ac, 8'h04, RESP_OKAY);
    core(ECS_KIND_CODE, 20'h00100, 16'h0);
    chk(np, 4, "all fetches external");
    chk({31'h0, ic}, 32'h0, "no internal fetch");
    chk(o_core_rdata, 16'h00ff, "low fetch data");
  endtask : t_sel0

  initial begin
    rst(1'h1, 1'h1);
    t_regs();
    t_sel1();
    t_data();
    t_stall();
    rst(1'h0, 1'h0);
    t_sel0();
    summarize();
  end
endmodule : ecs_top_tb_top
